// *** rtl/rcf_pkg.sv ***
// Constants, register map and carrier types of the frequency gradient protection step
// Overview of operation
// - Module enable switches protection on and raises module-active event
// - Selected module blocking event inhibits the module and shows module-blocked
// - Module blocking event number zero means never blocked
// - Source none deactivates the step; inputs a, b, c raise step-active
// - Selected step blocking event inhibits the step and shows step-blocked
// - Any phase below minimum start voltage blocks the step
// - After voltage recovers, release delay runs, then undervoltage blocking ends
// - Pick-up needs no module, step or undervoltage blocking
// - Pick-up raises event, runs trip delay, expiry raises trip
// - Pure gradient mode picks up when gradient exceeds maximum permissible gradient
// - Gradient slope sign must match configured supervision direction
// - Pure mode drops pick-up below limit minus hysteresis or wrong direction
// - Over-frequency mode also needs frequency above upper limit
// - Over-frequency mode also drops pick-up when frequency falls below upper limit
// - Under-frequency mode needs frequency below lower limit plus gradient terms
// - With grid code option the third input gives no frequency
// - Maximum gradient is gradient limit times impedance factor
// - Direction none supervises both signs; positive or negative only that sign
package rcf_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS       = 1_000_000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int N_EVT         = 64;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_BLK_SEL  = 8'h04;
    localparam logic [7:0] ADDR_MIN_VOLT = 8'h08;
    localparam logic [7:0] ADDR_REL_DLY  = 8'h0c;
    localparam logic [7:0] ADDR_FREQ_LIM = 8'h10;
    localparam logic [7:0] ADDR_GRAD     = 8'h14;
    localparam logic [7:0] ADDR_IMPED    = 8'h18;
    localparam logic [7:0] ADDR_TRIP_DLY = 8'h1c;
    localparam logic [7:0] ADDR_STATUS   = 8'h20;

    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_MODE_LSB  = 1;
    localparam int CTRL_DIR_LSB   = 3;
    localparam int CTRL_SRC_LSB   = 5;
    localparam int BLK_MOD_LSB    = 0;
    localparam int BLK_STEP_LSB   = 16;
    localparam int LIM_LOW_LSB    = 0;
    localparam int LIM_HIGH_LSB   = 16;
    localparam int GRAD_LIM_LSB   = 0;
    localparam int GRAD_HYST_LSB  = 16;
    localparam int IMPED_FRAC     = 8;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [13:0] RST_BLK_SEL   = 14'h0000;
    localparam logic [15:0] RST_MIN_VOLT  = 16'h0096;
    localparam logic [31:0] RST_REL_DLY   = 32'h0000_03e8;
    localparam logic [15:0] RST_LOW_FREQ  = 16'h1f40;
    localparam logic [15:0] RST_HIGH_FREQ = 16'h0000;
    localparam logic [15:0] RST_GRAD_LIM  = 16'h0064;
    localparam logic [15:0] RST_GRAD_HYST = 16'h0064;
    localparam logic [15:0] RST_IMPED     = 16'h0100;
    localparam logic [31:0] RST_TRIP_DLY  = 32'h0000_03e8;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {CRIT_GRAD, CRIT_OVER_FREQ, CRIT_UNDER_FREQ, CRIT_RSVD} rcf_crit_e;
    typedef enum logic [1:0] {DIR_NONE, DIR_POS, DIR_NEG, DIR_RSVD} rcf_dir_e;
    typedef enum logic [1:0] {SRC_NONE, SRC_A, SRC_B, SRC_C} rcf_src_e;

    typedef struct packed {
        logic        [15:0]      freq;      // 0.01 Hz
        logic signed [15:0]      grad;      // 0.01 Hz/s
        logic        [2:0][15:0] volt;      // 0.1 % of nominal line voltage
    } rcf_meas_s;

    typedef struct packed {
        logic      enable;
        rcf_crit_e criterion_select;
        rcf_dir_e  slope_direction;
        rcf_src_e  step_meas_source;
        logic [13:0] module_block_event_sel;
        logic [13:0] step_block_event_sel;
        logic [15:0] min_start_voltage;
        logic [31:0] min_voltage_release_delay;
        logic [15:0] low_freq_limit;
        logic [15:0] high_freq_limit;
        logic [15:0] gradient_limit;
        logic [15:0] gradient_hysteresis;
        logic [15:0] impedance_factor;
        logic [31:0] trip_delay;
    } rcf_cfg_s;

    typedef struct packed {
        logic module_active_evt;
        logic module_blocked_evt;
        logic step_active_evt;
        logic step_blocked_evt;
        logic pickup_evt;
        logic trip_evt;
    } rcf_evt_s;

endpackage

// *** rtl/rcf_delay_timer.sv ***
// Millisecond delay timer that flags expiry while its run input stays high
`timescale 1ns/1ps
module rcf_delay_timer #(
    parameter int TICK_CYC = rcf_pkg::TICK_CYC
) (
    input  wire logic        pclk,      // System clock
    input  wire logic        presetn,   // Asynchronous reset, active low
    input  wire logic        run,       // Timer runs while high, clears when low
    input  wire logic [31:0] delay_ms,  // Delay in milliseconds
    output logic             expired    // High once the delay has elapsed
);

    localparam int PW = $clog2(TICK_CYC + 1);

    typedef struct packed {
        logic [PW-1:0] prescale;
        logic [31:0]   ms_cnt;
        logic          expired;
    } rcf_tmr_s;

    rcf_tmr_s q;
    rcf_tmr_s d;

    always_comb begin
        d = q;
        if (!run) begin
            d = '0;
        end else if (q.ms_cnt >= delay_ms) begin
            d.expired = 1'b1;
        end else if (q.prescale == PW'(TICK_CYC - 1)) begin
            d.prescale = '0;
            d.ms_cnt   = q.ms_cnt + 32'h0000_0001;
        end else begin
            d.prescale = q.prescale + PW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired = q.expired;

endmodule // rcf_delay_timer

// *** rtl/rcf_step.sv ***
// Frequency gradient protection step with APB configuration registers
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module rcf_step #(
    parameter int TICK_CYC = rcf_pkg::TICK_CYC,
    parameter int N_EVT    = rcf_pkg::N_EVT
) (
    input  wire logic                  pclk,             // System clock
    input  wire logic                  presetn,          // Asynchronous reset, active low
    input  wire logic [7:0]            paddr,            // APB byte address
    input  wire logic                  psel,             // APB select
    input  wire logic                  penable,          // APB enable
    input  wire logic                  pwrite,           // APB write
    input  wire logic [31:0]           pwdata,           // APB write data
    output logic                       pready,           // APB ready
    output logic [31:0]                prdata,           // APB read data
    output logic                       pslverr,          // APB error on unmapped address
    input  wire rcf_pkg::rcf_meas_s [2:0] meas,          // Measurements of inputs a, b, c
    input  wire logic [N_EVT-1:0]      block_events,     // Event vector for blocking selection
    input  wire logic                  grid_code_option, // Variant built to grid code option
    output rcf_pkg::rcf_evt_s          events            // Status, pick-up and trip events
);

    localparam int EW = $clog2(N_EVT);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        rcf_pkg::rcf_cfg_s cfg;
        rcf_pkg::rcf_evt_s evt;
        logic              uv_block;
        logic              pick;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } rcf_state_s;

    rcf_state_s q;
    rcf_state_s d;
    logic       rel_run;
    logic       rel_expired;
    logic       trip_expired;

    // A configured event number past the end of the vector never blocks
    function automatic logic evt_hit(input logic [13:0] sel, input logic [N_EVT-1:0] vec);
        logic hit;
        hit = 1'b0;
        if (sel != 14'h0000 && 32'(sel) < N_EVT) begin
            hit = vec[sel[EW-1:0]];
        end
        return hit;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [31:0]        rd_word;
        logic               rd_hit;
        logic               step_on;
        logic               freq_ok;
        logic               uv;
        logic               mod_blk;
        logic               step_blk;
        logic               allow;
        logic               dir_ok;
        logic               gate_set;
        logic               gate_hold;
        logic [16:0]        mag;
        logic [31:0]        prod;
        logic [23:0]        grad_max;
        logic [23:0]        reset_lim;
        rcf_pkg::rcf_meas_s m;

        rd_word   = '0;
        rd_hit    = 1'b1;
        step_on   = 1'b0;
        freq_ok   = 1'b0;
        uv        = 1'b0;
        mod_blk   = 1'b0;
        step_blk  = 1'b0;
        allow     = 1'b0;
        dir_ok    = 1'b0;
        gate_set  = 1'b0;
        gate_hold = 1'b0;
        mag       = '0;
        prod      = '0;
        grad_max  = '0;
        reset_lim = '0;
        m         = '0;
        d         = q;
        rel_run   = 1'b0;

        // ************************************************************
        // APB slave: one wait cycle, write lands when pready is seen
        // ************************************************************
        case (paddr)
            rcf_pkg::ADDR_CTRL: begin
                rd_word[rcf_pkg::CTRL_EN_BIT]                        = q.cfg.enable;
                rd_word[rcf_pkg::CTRL_MODE_LSB +: 2]                 = q.cfg.criterion_select;
                rd_word[rcf_pkg::CTRL_DIR_LSB +: 2]                  = q.cfg.slope_direction;
                rd_word[rcf_pkg::CTRL_SRC_LSB +: 2]                  = q.cfg.step_meas_source;
            end
            rcf_pkg::ADDR_BLK_SEL: begin
                rd_word[rcf_pkg::BLK_MOD_LSB +: 14]  = q.cfg.module_block_event_sel;
                rd_word[rcf_pkg::BLK_STEP_LSB +: 14] = q.cfg.step_block_event_sel;
            end
            rcf_pkg::ADDR_MIN_VOLT: rd_word[15:0] = q.cfg.min_start_voltage;
            rcf_pkg::ADDR_REL_DLY:  rd_word = q.cfg.min_voltage_release_delay;
            rcf_pkg::ADDR_FREQ_LIM: begin
                rd_word[rcf_pkg::LIM_LOW_LSB +: 16]  = q.cfg.low_freq_limit;
                rd_word[rcf_pkg::LIM_HIGH_LSB +: 16] = q.cfg.high_freq_limit;
            end
            rcf_pkg::ADDR_GRAD: begin
                rd_word[rcf_pkg::GRAD_LIM_LSB +: 16]  = q.cfg.gradient_limit;
                rd_word[rcf_pkg::GRAD_HYST_LSB +: 16] = q.cfg.gradient_hysteresis;
            end
            rcf_pkg::ADDR_IMPED:    rd_word[15:0] = q.cfg.impedance_factor;
            rcf_pkg::ADDR_TRIP_DLY: rd_word = q.cfg.trip_delay;
            rcf_pkg::ADDR_STATUS:   rd_word[6:0] = {q.uv_block, q.evt};
            default:                rd_hit = 1'b0;
        endcase

        // Read data is latched only in the first access cycle and holds until the next access
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        if (psel && penable && !q.pready) begin
            d.pready  = 1'b1;
            d.pslverr = !rd_hit;
            d.prdata  = pwrite ? 32'h0000_0000 : rd_word;
        end

        if (psel && penable && q.pready && pwrite) begin
            case (paddr)
                rcf_pkg::ADDR_CTRL: begin
                    d.cfg.enable           = pwdata[rcf_pkg::CTRL_EN_BIT];
                    d.cfg.criterion_select = rcf_pkg::rcf_crit_e'(pwdata[rcf_pkg::CTRL_MODE_LSB +: 2]);
                    d.cfg.slope_direction  = rcf_pkg::rcf_dir_e'(pwdata[rcf_pkg::CTRL_DIR_LSB +: 2]);
                    d.cfg.step_meas_source = rcf_pkg::rcf_src_e'(pwdata[rcf_pkg::CTRL_SRC_LSB +: 2]);
                end
                rcf_pkg::ADDR_BLK_SEL: begin
                    d.cfg.module_block_event_sel = pwdata[rcf_pkg::BLK_MOD_LSB +: 14];
                    d.cfg.step_block_event_sel   = pwdata[rcf_pkg::BLK_STEP_LSB +: 14];
                end
                rcf_pkg::ADDR_MIN_VOLT: d.cfg.min_start_voltage         = pwdata[15:0];
                rcf_pkg::ADDR_REL_DLY:  d.cfg.min_voltage_release_delay = pwdata;
                rcf_pkg::ADDR_FREQ_LIM: begin
                    d.cfg.low_freq_limit  = pwdata[rcf_pkg::LIM_LOW_LSB +: 16];
                    d.cfg.high_freq_limit = pwdata[rcf_pkg::LIM_HIGH_LSB +: 16];
                end
                rcf_pkg::ADDR_GRAD: begin
                    d.cfg.gradient_limit      = pwdata[rcf_pkg::GRAD_LIM_LSB +: 16];
                    d.cfg.gradient_hysteresis = pwdata[rcf_pkg::GRAD_HYST_LSB +: 16];
                end
                rcf_pkg::ADDR_IMPED:    d.cfg.impedance_factor = pwdata[15:0];
                rcf_pkg::ADDR_TRIP_DLY: d.cfg.trip_delay       = pwdata;
                default: ;
            endcase
        end

        // ************************************************************
        // Source selection and blocking
        // ************************************************************
        step_on = q.cfg.enable && (q.cfg.step_meas_source != rcf_pkg::SRC_NONE);
        // Source none forms no index, so nothing past the third input is ever read
        case (q.cfg.step_meas_source)
            rcf_pkg::SRC_A: m = meas[0];
            rcf_pkg::SRC_B: m = meas[1];
            rcf_pkg::SRC_C: m = meas[2];
            default:        m = '0;
        endcase
        freq_ok = !(grid_code_option && q.cfg.step_meas_source == rcf_pkg::SRC_C);

        for (int p = 0; p < 3; p++) begin
            if (m.volt[p] < q.cfg.min_start_voltage) begin
                uv = 1'b1;
            end
        end

        mod_blk  = q.cfg.enable && evt_hit(q.cfg.module_block_event_sel, block_events);
        step_blk = step_on && evt_hit(q.cfg.step_block_event_sel, block_events);

        // Blocking is held through the release delay so a flickering voltage cannot trip
        if (!step_on) begin
            d.uv_block = 1'b0;
        end else if (uv) begin
            d.uv_block = 1'b1;
        end else if (q.uv_block && rel_expired) begin
            d.uv_block = 1'b0;
        end
        rel_run = step_on && q.uv_block && !uv;

        // ************************************************************
        // Gradient criteria
        // ************************************************************
        mag       = m.grad[15] ? 17'(-$signed({m.grad[15], m.grad})) : {1'b0, m.grad};
        prod      = q.cfg.gradient_limit * q.cfg.impedance_factor;
        grad_max  = prod[31:rcf_pkg::IMPED_FRAC];
        reset_lim = (grad_max > 24'(q.cfg.gradient_hysteresis)) ?
                    grad_max - 24'(q.cfg.gradient_hysteresis) : 24'h00_0000;

        case (q.cfg.slope_direction)
            rcf_pkg::DIR_NONE: dir_ok = 1'b1;
            rcf_pkg::DIR_POS:  dir_ok = (m.grad > 16'sh0000);
            rcf_pkg::DIR_NEG:  dir_ok = (m.grad < 16'sh0000);
            default:           dir_ok = 1'b0;
        endcase

        case (q.cfg.criterion_select)
            rcf_pkg::CRIT_GRAD: begin
                gate_set  = 1'b1;
                gate_hold = 1'b1;
            end
            rcf_pkg::CRIT_OVER_FREQ: begin
                gate_set  = m.freq > q.cfg.high_freq_limit;
                gate_hold = m.freq >= q.cfg.high_freq_limit;
            end
            rcf_pkg::CRIT_UNDER_FREQ: begin
                gate_set  = m.freq < q.cfg.low_freq_limit;
                gate_hold = m.freq <= q.cfg.low_freq_limit;
            end
            default: begin
                gate_set  = 1'b0;
                gate_hold = 1'b0;
            end
        endcase

        allow = step_on && freq_ok && !mod_blk && !step_blk && !q.uv_block && !uv;

        if (!allow) begin
            d.pick = 1'b0;
        end else if (q.pick) begin
            d.pick = (24'(mag) >= reset_lim) && dir_ok && gate_hold;
        end else begin
            d.pick = (24'(mag) > grad_max) && dir_ok && gate_set;
        end

        // ************************************************************
        // Events
        // ************************************************************
        d.evt.module_active_evt  = q.cfg.enable;
        d.evt.module_blocked_evt = mod_blk;
        d.evt.step_active_evt    = step_on;
        d.evt.step_blocked_evt   = step_blk || d.uv_block;
        d.evt.pickup_evt         = d.pick;
        d.evt.trip_evt           = d.pick && q.pick && trip_expired;
    end

    // ****************************************************************
    // Delay timers
    // ****************************************************************
    rcf_delay_timer #(
        .TICK_CYC (TICK_CYC)
    ) u_release_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (rel_run),
        .delay_ms (q.cfg.min_voltage_release_delay),
        .expired  (rel_expired)
    );

    rcf_delay_timer #(
        .TICK_CYC (TICK_CYC)
    ) u_trip_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (q.pick),
        .delay_ms (q.cfg.trip_delay),
        .expired  (trip_expired)
    );

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q                               <= '0;
            q.cfg.criterion_select          <= rcf_pkg::CRIT_GRAD;
            q.cfg.slope_direction           <= rcf_pkg::DIR_NONE;
            q.cfg.step_meas_source          <= rcf_pkg::SRC_A;
            q.cfg.module_block_event_sel    <= rcf_pkg::RST_BLK_SEL;
            q.cfg.step_block_event_sel      <= rcf_pkg::RST_BLK_SEL;
            q.cfg.min_start_voltage         <= rcf_pkg::RST_MIN_VOLT;
            q.cfg.min_voltage_release_delay <= rcf_pkg::RST_REL_DLY;
            q.cfg.low_freq_limit            <= rcf_pkg::RST_LOW_FREQ;
            q.cfg.high_freq_limit           <= rcf_pkg::RST_HIGH_FREQ;
            q.cfg.gradient_limit            <= rcf_pkg::RST_GRAD_LIM;
            q.cfg.gradient_hysteresis       <= rcf_pkg::RST_GRAD_HYST;
            q.cfg.impedance_factor          <= rcf_pkg::RST_IMPED;
            q.cfg.trip_delay                <= rcf_pkg::RST_TRIP_DLY;
        end else begin
            q <= d;
        end
    end

    assign pready  = q.pready;
    assign prdata  = q.prdata;
    assign pslverr = q.pslverr;
    assign events  = q.evt;

endmodule // rcf_step

// *** verification/rcf_meas_model.sv ***
// Measurement source model of the three voltage inputs
`timescale 1ns/1ps
module rcf_meas_model (
    input  wire logic [15:0]         f,    // Frequency in 0.01 Hz
    input  wire logic signed [15:0]  g,    // Gradient in 0.01 Hz/s
    input  wire logic [15:0]         v,    // Voltage of the weak phase
    output rcf_pkg::rcf_meas_s [2:0] meas  // Values of inputs a, b, c
);
    // ****************************************************************
    // Source values
    // ****************************************************************
    // Only one phase follows v, so blocking must react to a single phase
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            meas[i] = '{freq: f, grad: g, volt: {v, 16'h03e8, 16'h03e8}};
        end
    end
endmodule // rcf_meas_model

// *** verification/rcf_step_chk.sv ***
// Port-level assertions of the protection step
`timescale 1ns/1ps
module rcf_step_chk (
    input wire logic              pclk,    // System clock
    input wire logic              presetn, // Reset, active low
    input wire logic              psel,    // APB select
    input wire logic              penable, // APB enable
    input wire logic              pready,  // APB ready
    input wire logic              pslverr, // APB error
    input wire rcf_pkg::rcf_evt_s events   // Protection events
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc; $rose(psel && penable); endsequence
    sequence s_ans; pready ##1 !pready; endsequence
    a_ready_timing: assert property (s_acc |=> s_ans)
        else $error("ready timing");
    a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside answer");
    a_trip_needs_pick: assert property (events.trip_evt |-> events.pickup_evt)
        else $error("trip without pickup");
    a_trip_after_pick: assert property ($rose(events.trip_evt) |-> $past(events.pickup_evt))
        else $error("trip too early");
    a_pick_needs_step: assert property (events.pickup_evt |-> events.step_active_evt)
        else $error("pickup on inactive step");
    a_step_blk_quiet: assert property (events.step_blocked_evt |-> !events.pickup_evt)
        else $error("pickup while step blocked");
    a_mod_blk_quiet: assert property (events.module_blocked_evt |-> !events.pickup_evt)
        else $error("pickup while module blocked");
    a_blk_needs_on: assert property (events.module_blocked_evt |-> events.module_active_evt)
        else $error("blocked while off");
    a_pick_needs_on: assert property (events.pickup_evt |-> events.module_active_evt)
        else $error("pickup while off");
endmodule // rcf_step_chk

// *** verification/testbench.sv ***
// Self-checking testbench of the frequency gradient protection step
`timescale 1ns/1ps
module testbench;
    // ****************************************************************
    // Bench
    // ****************************************************************
    logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, grid, err;
    logic [7:0]               paddr;
    logic [31:0]              pwdata, prdata, rd;
    logic [63:0]              blk;
    logic [15:0]              f, v;
    logic signed [15:0]       g;
    rcf_pkg::rcf_meas_s [2:0] meas;
    rcf_pkg::rcf_evt_s        ev;
    int                       num_errors = 0, samples_checked = 0, n;
    rcf_step #(.TICK_CYC(4)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .meas(meas), .block_events(blk), .grid_code_option(grid), .events(ev));
    rcf_meas_model pm (.f(f), .g(g), .v(v), .meas(meas));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1) begin
            num_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [1:0] d, input logic [1:0] s);
        return {25'h0, s, d, m, 1'b1};
    endfunction
    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask
    task automatic setm(input logic [15:0] nf, input logic signed [15:0] ng, input logic [15:0] nv);
        @(posedge pclk);
        {f, g, v} <= {nf, ng, nv};
    endtask
    task automatic pick(input logic e);
        wt(4);
        chk(ev.pickup_evt === e, "pickup");
    endtask
    task automatic s_regs;
        logic [7:0]  a [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
        logic [31:0] e [10] = '{32'h20, 32'h0, 32'h96, 32'h3e8, 32'h1f40, 32'h00640064, 32'h100, 32'h3e8,
                                32'h0, 32'h0};
        for (int i = 0; i < 10; i++) begin
            apb(a[i], 1'b0, 32'h0);
            chk(rd === e[i] && err === (i == 9), "reg read");
        end
    endtask
    task automatic s_enable;
        chk(ev === '0, "reset events");
        for (int s = 0; s < 4; s++) begin
            apb(8'h00, 1'b1, ctrl(2'h0, 2'h0, 2'(s)));
            wt(3);
            chk(ev.module_active_evt === 1'b1 && ev.step_active_evt === (s != 0), "active");
        end
    endtask
    task automatic s_trip;
        apb(8'h14, 1'b1, 32'h0014_0064);
        apb(8'h1c, 1'b1, 32'h0000_0003);
        apb(8'h00, 1'b1, ctrl(2'h0, 2'h0, 2'h1));
        setm(16'h1388, 16'sh0096, 16'h03e8);
        n = 0;
        while (ev.trip_evt !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk(n >= 12 && n <= 18, "trip delay");
        setm(16'h1388, 16'sh005a, 16'h03e8);
        pick(1'b1);
        setm(16'h1388, 16'sh0046, 16'h03e8);
        pick(1'b0);
        chk(ev.trip_evt === 1'b0, "trip drop");
    endtask
    task automatic s_dir;
        apb(8'h00, 1'b1, ctrl(2'h0, 2'h1, 2'h1));
        setm(16'h1388, 16'sh0096, 16'h03e8);
        pick(1'b1);
        setm(16'h1388, -16'sh0096, 16'h03e8);
        pick(1'b0);
        apb(8'h00, 1'b1, ctrl(2'h0, 2'h2, 2'h1));
        pick(1'b1);
        apb(8'h00, 1'b1, ctrl(2'h0, 2'h3, 2'h1));
        pick(1'b0);
    endtask
    task automatic s_gate;
        logic [1:0]  m [6] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
        logic [15:0] q [6] = '{16'h0fa0, 16'h1770, 16'h0fa0, 16'h1388, 16'h12c0, 16'h12c0};
        logic        x [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        apb(8'h10, 1'b1, 32'h1388_1324);
        for (int i = 0; i < 6; i++) begin
            apb(8'h00, 1'b1, ctrl(m[i], 2'h0, 2'h1));
            setm(q[i], 16'sh0096, 16'h03e8);
            pick(x[i]);
        end
    endtask
    task automatic s_block;
        int         b [5] = '{5, 5, 7, 7, 0};
        logic [2:0] x [5] = '{3'b100, 3'b001, 3'b010, 3'b001, 3'b001};
        apb(8'h00, 1'b1, ctrl(2'h0, 2'h0, 2'h1));
        for (int i = 0; i < 5; i++) begin
            apb(8'h04, 1'b1, (i < 4) ? 32'h0007_0005 : 32'h0);
            blk[b[i]] <= (i % 2 == 0);
            wt(4);
            chk({ev.module_blocked_evt, ev.step_blocked_evt, ev.pickup_evt} === x[i], "block");
        end
    endtask
    task automatic s_uv;
        apb(8'h0c, 1'b1, 32'h0000_0002);
        apb(8'h08, 1'b1, 32'h0000_0096);
        setm(16'h1388, 16'sh0096, 16'h0064);
        wt(4);
        chk(ev.step_blocked_evt === 1'b1 && ev.pickup_evt === 1'b0, "undervoltage");
        setm(16'h1388, 16'sh0096, 16'h03e8);
        wt(4);
        chk(ev.step_blocked_evt === 1'b1, "early release");
        wt(12);
        chk(ev.step_blocked_evt === 1'b0 && ev.pickup_evt === 1'b1, "release");
    endtask
    task automatic s_grid_imped;
        apb(8'h00, 1'b1, ctrl(2'h0, 2'h0, 2'h3));
        grid <= 1'b1;
        pick(1'b0);
        @(posedge pclk);
        grid <= 1'b0;
        pick(1'b1);
        apb(8'h18, 1'b1, 32'h0000_0200);
        pick(1'b0);
        setm(16'h1388, 16'sh00d2, 16'h03e8);
        pick(1'b1);
    endtask
    task automatic test_done;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, grid} = 5'h00;
        {paddr, pwdata, blk, f, g, v} = {8'h00, 32'h0, 64'h0, 16'h1388, 16'h0000, 16'h03e8};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        s_regs;
        s_enable;
        s_trip;
        s_dir;
        s_gate;
        s_block;
        s_uv;
        s_grid_imped;
        test_done;
    end
    initial begin
        #500000;
        num_errors++;
        test_done;
    end
endmodule // testbench
bind rcf_step rcf_step_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .events(events));
